// ===== hw/external_internal_interrupt_ctrl.sv
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module external_internal_interrupt_ctrl
  import intc_pkg::*;
#(
  parameter int NUM_PERIPH = 4
) (
  input wire logic core_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins idle high, asynchronous
  input wire logic nonmaskPin,
  input wire logic [NUM_EXT-1:0] ext_request_pins,
  input wire logic [NUM_WAKE-1:0] wake_request_pins,
  // On-chip request events
  input wire logic timerAReq,
  input wire logic directXferReq,
  input wire logic [NUM_PERIPH-1:0] periphReq,
  // Core side
  input wire logic instrDone,
  input wire logic globalMask,
  input wire logic [15:0] nextPc,
  input wire logic [7:0] ccrIn,
  input wire logic [15:0] stackPtr,
  output logic reqValid,
  output logic [5:0] reqVector,
  output logic seqBusy,
  output logic stackWrite,
  output logic [15:0] stackAddr,
  output logic [15:0] stackData,
  output logic [15:0] newStackPtr,
  output logic setMask,
  output logic pcLoad,
  output logic [15:0] pcLoadValue,
  output logic handlerStart
);

  if (NUM_PERIPH < 1 || NUM_PERIPH > 16) begin : g_bad_periph
    $error("NUM_PERIPH must be 1 to 16");
  end

  localparam int NUM_PINS = 1 + NUM_EXT + NUM_WAKE;

  logic [7:0] wrAddr_ff;
  logic wrPend_ff;
  logic [31:0] hrdata_ff;
  logic addrPhase;
  logic [7:0] wdat;
  logic wrStrobe;

  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign wrStrobe = wrPend_ff;
  assign wdat = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  function automatic logic isWrite(input logic [7:0] ofs, input logic [7:0] a, input logic s);
    return s && (a == ofs);
  endfunction

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
    end else begin
      wrPend_ff <= addrPhase && hwrite && (hsize == HSIZE_WORD);
      wrAddr_ff <= {haddr[7:2], 2'b00};
    end
  end

  logic [7:0] edge_select_reg_one_ff;
  logic [7:0] edge_select_reg_two_ff;
  logic [7:0] port_mode_reg_one_ff;
  logic [7:0] port_mode_reg_five_ff;
  logic [7:0] request_enable_reg_ff;
  logic [15:0] periphEnable_ff;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      edge_select_reg_one_ff <= REG_RESET;
      edge_select_reg_two_ff <= REG_RESET;
      port_mode_reg_one_ff <= REG_RESET;
      port_mode_reg_five_ff <= REG_RESET;
      request_enable_reg_ff <= REG_RESET;
      periphEnable_ff <= 16'h0000;
    end else begin
      if (isWrite(OFS_EDGE_ONE, wrAddr_ff, wrStrobe)) begin
        edge_select_reg_one_ff <= wdat & 8'h8F;
      end
      if (isWrite(OFS_EDGE_TWO, wrAddr_ff, wrStrobe)) begin
        edge_select_reg_two_ff <= wdat & 8'h3F;
      end
      if (isWrite(OFS_PMODE_ONE, wrAddr_ff, wrStrobe)) begin
        port_mode_reg_one_ff <= wdat & 8'h0F;
      end
      if (isWrite(OFS_PMODE_FIVE, wrAddr_ff, wrStrobe)) begin
        port_mode_reg_five_ff <= wdat & 8'h3F;
      end
      if (isWrite(OFS_REQ_ENABLE, wrAddr_ff, wrStrobe)) begin
        request_enable_reg_ff <= wdat & 8'hEF;
      end
      if (isWrite(OFS_PERIPH_EN, wrAddr_ff, wrStrobe)) begin
        periphEnable_ff <= hwdata[15:0];
      end
    end
  end

  logic [NUM_PINS-1:0] pinMeta_ff;
  logic [NUM_PINS-1:0] pinSync_ff;
  logic [NUM_PINS-1:0] pinPrev_ff;
  logic [NUM_PINS-1:0] pinMode;
  logic [NUM_PINS-1:0] pinEdgeRise;
  logic [NUM_PINS-1:0] pinLevel;
  logic [NUM_PINS-1:0] pinHit;

  assign pinMode = {port_mode_reg_five_ff[NUM_WAKE-1:0],
                    port_mode_reg_one_ff[NUM_EXT-1:0], 1'b1};
  assign pinEdgeRise = {edge_select_reg_two_ff[NUM_WAKE-1:0],
                        edge_select_reg_one_ff[NUM_EXT-1:0],
                        edge_select_reg_one_ff[NMI_EDGE_BIT]};

  // Two-stage sync then compare with previous sample
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pinMeta_ff <= '1;
      pinSync_ff <= '1;
      pinPrev_ff <= '1;
    end else begin
      pinMeta_ff <= {wake_request_pins, ext_request_pins, nonmaskPin};
      pinSync_ff <= pinMeta_ff;
      pinPrev_ff <= pinLevel;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_edge
      // A pin outside interrupt mode reads idle high, so a mode change can edge
      assign pinLevel[gi] = pinMode[gi] ? pinSync_ff[gi] : 1'b1;
      assign pinHit[gi] = pinEdgeRise[gi] ? (pinLevel[gi] && !pinPrev_ff[gi])
                                          : (!pinLevel[gi] && pinPrev_ff[gi]);
    end
  endgenerate

  logic [7:0] request_flag_reg_ff;
  logic [7:0] wake_flag_reg_ff;
  logic [15:0] periphFlag_ff;
  logic nmiPend_ff;
  logic [7:0] reqSet;
  logic [7:0] reqKeep;
  logic [7:0] wakeKeep;
  logic accept;
  logic acceptNmi;

  assign reqSet = {directXferReq, timerAReq, 2'b00, pinHit[NUM_EXT:1]};
  assign reqKeep = isWrite(OFS_REQ_FLAG, wrAddr_ff, wrStrobe) ? wdat : 8'hFF;
  assign wakeKeep = isWrite(OFS_WAKE_FLAG, wrAddr_ff, wrStrobe) ? wdat : 8'hFF;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      request_flag_reg_ff <= REG_RESET;
      wake_flag_reg_ff <= REG_RESET;
    end else begin
      // Set wins over a simultaneous clear
      request_flag_reg_ff <= ((request_flag_reg_ff & reqKeep) | reqSet) & 8'hCF;
      wake_flag_reg_ff <= ((wake_flag_reg_ff & wakeKeep)
                          | {2'b00, pinHit[NUM_PINS-1:NUM_EXT+1]}) & 8'h3F;
    end
  end

  // Peripheral status flags; cleared by writing 0 at their offset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      periphFlag_ff <= 16'h0000;
    end else if (isWrite(OFS_PERIPH_FLAG, wrAddr_ff, wrStrobe)) begin
      periphFlag_ff[NUM_PERIPH-1:0] <= (periphFlag_ff[NUM_PERIPH-1:0]
                                       & hwdata[NUM_PERIPH-1:0]) | periphReq;
    end else begin
      periphFlag_ff[NUM_PERIPH-1:0] <= periphFlag_ff[NUM_PERIPH-1:0] | periphReq;
    end
  end

  // Non-maskable request is held until accepted
  always_ff @(posedge core_clk) begin
    if (reset) begin
      nmiPend_ff <= 1'b0;
    end else if (pinHit[0]) begin
      nmiPend_ff <= 1'b1;
    end else if (acceptNmi) begin
      nmiPend_ff <= 1'b0;
    end
  end

  logic [NUM_EXT-1:0] extActive;
  logic wakeActive;
  logic timerAActive;
  logic directActive;
  logic [15:0] periphActive;
  logic maskActive;
  logic [5:0] maskVector;

  assign extActive = request_flag_reg_ff[NUM_EXT-1:0] & request_enable_reg_ff[NUM_EXT-1:0];
  // Single group enable for the wake pins
  assign wakeActive = (|wake_flag_reg_ff) && request_enable_reg_ff[WAKE_GROUP_EN_BIT];
  assign timerAActive = request_flag_reg_ff[TIMERA_BIT] && request_enable_reg_ff[TIMERA_BIT];
  assign directActive = request_flag_reg_ff[DIRECT_BIT] && request_enable_reg_ff[DIRECT_BIT];
  assign periphActive = periphFlag_ff & periphEnable_ff;

  // Lowest vector number wins, scanned from highest down
  always_comb begin
    maskActive = 1'b0;
    maskVector = VEC_NMI;
    for (int i = NUM_PERIPH - 1; i >= 0; i--) begin
      if (periphActive[i]) begin
        maskActive = 1'b1;
        maskVector = VEC_PERIPH0 + 6'(i);
      end
    end
    if (directActive) begin
      maskActive = 1'b1;
      maskVector = VEC_DIRECT;
    end
    if (timerAActive) begin
      maskActive = 1'b1;
      maskVector = VEC_TIMERA;
    end
    if (wakeActive) begin
      maskActive = 1'b1;
      maskVector = VEC_WAKE;
    end
    for (int i = NUM_EXT - 1; i >= 0; i--) begin
      if (extActive[i]) begin
        maskActive = 1'b1;
        maskVector = VEC_EXT0 + 6'(i);
      end
    end
  end

  seq_state_t seqState_ff;
  logic [2:0] seqCount_ff;
  logic armed_ff;
  logic [5:0] acceptedVec_ff;
  logic [15:0] savedPc_ff;
  logic [7:0] savedCcr_ff;
  logic [15:0] spBase_ff;
  logic lastCycle;

  // Non-maskable first, else best maskable one
  // Maskable ones wait while the mask bit is 1
  // Nothing is presented until the first instruction has run
  assign reqValid = armed_ff && (seqState_ff == SEQ_IDLE)
                    && (nmiPend_ff || (maskActive && !globalMask));
  assign reqVector = nmiPend_ff ? VEC_NMI : maskVector;
  assign accept = reqValid && instrDone;
  assign acceptNmi = accept && nmiPend_ff;

  // Armed by the first completed instruction
  always_ff @(posedge core_clk) begin
    if (reset) begin
      armed_ff <= 1'b0;
    end else if (instrDone) begin
      armed_ff <= 1'b1;
    end
  end

  always_comb begin
    unique case (seqState_ff)
      SEQ_STACK: lastCycle = (seqCount_ff == STACK_STATES - 3'h1);
      SEQ_VECTOR: lastCycle = (seqCount_ff == VECTOR_STATES - 3'h1);
      SEQ_FETCH: lastCycle = (seqCount_ff == FETCH_STATES - 3'h1);
      SEQ_INTERNAL: lastCycle = (seqCount_ff == INTERNAL_STATES - 3'h1);
      SEQ_IDLE: lastCycle = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      seqState_ff <= SEQ_IDLE;
      seqCount_ff <= 3'h0;
    end else begin
      seqCount_ff <= (lastCycle || seqState_ff == SEQ_IDLE) ? 3'h0 : seqCount_ff + 3'h1;
      unique case (seqState_ff)
        SEQ_IDLE: if (accept) begin
          seqState_ff <= SEQ_STACK;
        end
        SEQ_STACK: if (lastCycle) begin
          seqState_ff <= SEQ_VECTOR;
        end
        SEQ_VECTOR: if (lastCycle) begin
          seqState_ff <= SEQ_FETCH;
        end
        SEQ_FETCH: if (lastCycle) begin
          seqState_ff <= SEQ_INTERNAL;
        end
        SEQ_INTERNAL: if (lastCycle) begin
          seqState_ff <= SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      acceptedVec_ff <= VEC_NMI;
      savedPc_ff <= 16'h0000;
      savedCcr_ff <= 8'h00;
      spBase_ff <= 16'h0000;
    end else if (accept) begin
      acceptedVec_ff <= reqVector;
      // Stacked counter is the next instruction
      savedPc_ff <= nextPc;
      savedCcr_ff <= ccrIn;
      // Stack word accesses ignore address bit 0
      spBase_ff <= {stackPtr[15:1], 1'b0};
    end
  end

  // Outputs to the core, registered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stackWrite <= 1'b0;
      stackAddr <= 16'h0000;
      stackData <= 16'h0000;
      newStackPtr <= 16'h0000;
      setMask <= 1'b0;
      pcLoad <= 1'b0;
      pcLoadValue <= 16'h0000;
      handlerStart <= 1'b0;
    end else begin
      // Counter pushed first, condition codes below it
      stackWrite <= (seqState_ff == SEQ_STACK) && seqCount_ff[0];
      if (seqState_ff == SEQ_STACK && seqCount_ff == 3'h1) begin
        stackAddr <= spBase_ff - 16'h0002;
        stackData <= savedPc_ff;
      end else if (seqState_ff == SEQ_STACK && seqCount_ff == 3'h3) begin
        stackAddr <= spBase_ff - 16'h0004;
        stackData <= {savedCcr_ff, savedCcr_ff};
        newStackPtr <= spBase_ff - 16'h0004;
      end
      // Mask bit set once stacking ends
      setMask <= (seqState_ff == SEQ_STACK) && lastCycle;
      // Vector address loaded into the counter
      pcLoad <= (seqState_ff == SEQ_VECTOR) && lastCycle;
      if ((seqState_ff == SEQ_VECTOR) && lastCycle) begin
        pcLoadValue <= {9'h000, acceptedVec_ff, 1'b0};
      end
      handlerStart <= (seqState_ff == SEQ_INTERNAL) && lastCycle;
    end
  end

  assign seqBusy = (seqState_ff != SEQ_IDLE);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      hrdata_ff <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      unique case ({haddr[7:2], 2'b00})
        OFS_EDGE_ONE: hrdata_ff <= {24'h000000, edge_select_reg_one_ff};
        OFS_EDGE_TWO: hrdata_ff <= {24'h000000, edge_select_reg_two_ff};
        OFS_PMODE_ONE: hrdata_ff <= {24'h000000, port_mode_reg_one_ff};
        OFS_PMODE_FIVE: hrdata_ff <= {24'h000000, port_mode_reg_five_ff};
        OFS_REQ_FLAG: hrdata_ff <= {24'h000000, request_flag_reg_ff};
        OFS_REQ_ENABLE: hrdata_ff <= {24'h000000, request_enable_reg_ff};
        OFS_WAKE_FLAG: hrdata_ff <= {24'h000000, wake_flag_reg_ff | WAKE_FLAG_RSVD};
        OFS_PERIPH_EN: hrdata_ff <= {16'h0000, periphEnable_ff};
        OFS_PERIPH_FLAG: hrdata_ff <= {16'h0000, periphFlag_ff};
        OFS_STATUS: hrdata_ff <= {16'h0000, 2'b00, reqVector, 4'h0,
                                  nmiPend_ff, reqValid, seqBusy, armed_ff};
        default: hrdata_ff <= 32'h00000000;
      endcase
    end
  end

endmodule

// ===== hw/intc_pkg.sv
package intc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_EDGE_ONE = 8'h00;
  localparam logic [7:0] OFS_EDGE_TWO = 8'h04;
  localparam logic [7:0] OFS_PMODE_ONE = 8'h08;
  localparam logic [7:0] OFS_PMODE_FIVE = 8'h0C;
  localparam logic [7:0] OFS_REQ_FLAG = 8'h10;
  localparam logic [7:0] OFS_REQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_WAKE_FLAG = 8'h18;
  localparam logic [7:0] OFS_PERIPH_EN = 8'h1C;
  localparam logic [7:0] OFS_PERIPH_FLAG = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // Field positions
  localparam int NMI_EDGE_BIT = 7;
  localparam int WAKE_GROUP_EN_BIT = 5;
  localparam int TIMERA_BIT = 6;
  localparam int DIRECT_BIT = 7;
  localparam int NUM_EXT = 4;
  localparam int NUM_WAKE = 6;
  localparam logic [7:0] WAKE_FLAG_RSVD = 8'hC0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Vector numbers; lower number wins among maskable sources
  localparam logic [5:0] VEC_NMI = 6'h07;
  localparam logic [5:0] VEC_EXT0 = 6'h08;
  localparam logic [5:0] VEC_WAKE = 6'h0C;
  localparam logic [5:0] VEC_TIMERA = 6'h0D;
  localparam logic [5:0] VEC_DIRECT = 6'h0E;
  localparam logic [5:0] VEC_PERIPH0 = 6'h10;
  // Acceptance overhead in states (clock cycles)
  localparam logic [2:0] STACK_STATES = 3'h4;
  localparam logic [2:0] VECTOR_STATES = 3'h2;
  localparam logic [2:0] FETCH_STATES = 3'h4;
  localparam logic [2:0] INTERNAL_STATES = 3'h4;
  // AHB codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum {SEQ_IDLE, SEQ_STACK, SEQ_VECTOR, SEQ_FETCH, SEQ_INTERNAL} seq_state_t;
endpackage

// ===== verification/core_model.sv
`timescale 1ns/1ps
module core_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [4:0] instrLen,
  input wire logic holdMask,
  input wire logic ret,
  input wire logic seqBusy,
  input wire logic setMask,
  output logic instrDone,
  output logic globalMask,
  output logic [15:0] nextPc,
  output logic [7:0] ccrIn
);
  logic [4:0] cnt_ff;
  logic mask_ff;
  assign globalMask = mask_ff | holdMask;
  assign ccrIn = {globalMask, 7'h2A};
  // instructions of instrLen states, none while stacking
  always_ff @(posedge core_clk) begin
    if (reset || seqBusy || instrLen == 5'h00) begin
      cnt_ff <= 5'h00;
      instrDone <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff + 5'h01 >= instrLen) ? 5'h00 : cnt_ff + 5'h01;
      instrDone <= (cnt_ff + 5'h01 >= instrLen);
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      nextPc <= 16'h0100;
    end else if (instrDone) begin
      nextPc <= nextPc + 16'h0002;
    end
  end
  // mask set by acceptance, cleared on return
  always_ff @(posedge core_clk) begin
    if (reset || ret) begin
      mask_ff <= 1'b0;
    end else if (setMask) begin
      mask_ff <= 1'b1;
    end
  end
endmodule

// ===== verification/external_internal_interrupt_ctrl_tb.sv
`timescale 1ns/1ps
module external_internal_interrupt_ctrl_tb import intc_pkg::*;;
  logic core_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic holdMask = 1'b1, ret = 1'b0, nonmaskPin = 1'b1, timerAReq = 1'b0, directXferReq = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, d, seed = 32'h000035EA;
  logic [3:0] ext_request_pins = 4'hF, periphReq = 4'h0, edg;
  logic [5:0] wake_request_pins = 6'h3F, wedg;
  logic [4:0] instrLen = 5'h00;
  logic [15:0] stackPtr = 16'h0FFE;
  int fails = 0, totalChecks = 0;
  logic hreadyout, hresp, reqValid, seqBusy, setMask, pcLoad, handlerStart, instrDone, globalMask;
  logic [31:0] hrdata;
  logic [5:0] reqVector;
  logic [15:0] pcLoadValue, nextPc, newStackPtr;
  logic [7:0] ccrIn;
  logic [5:0] pv [7] = '{VEC_EXT0 + 6'h02, VEC_TIMERA, VEC_DIRECT, VEC_PERIPH0,
    VEC_PERIPH0 + 6'h01, VEC_PERIPH0 + 6'h02, VEC_PERIPH0 + 6'h03};
  logic [7:0] pa [7] = '{OFS_REQ_FLAG, OFS_REQ_FLAG, OFS_REQ_FLAG, OFS_PERIPH_FLAG,
    OFS_PERIPH_FLAG, OFS_PERIPH_FLAG, OFS_PERIPH_FLAG};
  logic [31:0] pd [7] = '{32'hC0, 32'h80, 32'h0, 32'hE, 32'hC, 32'h8, 32'h0};

  external_internal_interrupt_ctrl #(.NUM_PERIPH(4)) u_dut (.core_clk, .reset, .hsel, .haddr,
    .htrans, .hwrite, .hsize(HSIZE_WORD), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .nonmaskPin, .ext_request_pins, .wake_request_pins, .timerAReq, .directXferReq,
    .periphReq, .instrDone, .globalMask, .nextPc, .ccrIn, .stackPtr, .reqValid, .reqVector,
    .seqBusy, .stackWrite(), .stackAddr(), .stackData(), .newStackPtr, .setMask, .pcLoad,
    .pcLoadValue, .handlerStart);
  core_model u_core (.core_clk, .reset, .instrLen, .holdMask, .ret, .seqBusy, .setMask,
    .instrDone, .globalMask, .nextPc, .ccrIn);

  always #25 core_clk = ~core_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] vecAddr(input logic [5:0] v);
    return {25'h0, v, 1'b0};
  endfunction
  task automatic finish_test();
    if (fails == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic busAddr(input logic [7:0] a, input logic w);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask
  task automatic busWr(input logic [7:0] a, input logic [31:0] v);
    busAddr(a, 1'b1);
    hwdata <= v;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask
  task automatic busRd(input logic [7:0] a, output logic [31:0] r);
    busAddr(a, 1'b0);
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask
  // Waits for one acceptance, clears its source, then returns from the handler
  task automatic waitAcc(input logic [5:0] v, input logic [7:0] a, input logic [31:0] c);
    stackPtr <= 16'(rnd());
    instrLen <= 5'(rnd() % 32'h17) + 5'h01;
    for (int k = 0; k < 300 && pcLoad !== 1'b1; k++) @(posedge core_clk);
    chk("vectorAddr", {16'h0, pcLoadValue}, vecAddr(v));
    chk("newStackPtr", {16'h0, newStackPtr}, {16'h0, stackPtr[15:1], 1'b0} - 32'h4);
    for (int k = 0; k < 30 && handlerStart !== 1'b1; k++) @(posedge core_clk);
    busWr(a, c);
    ret <= 1'b1;
    @(posedge core_clk);
    ret <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    nonmaskPin <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("seqAfterReset", 32'({pcLoad, seqBusy, setMask}), 32'h0);
    chk("earlyReq", 32'(reqValid), 32'h0);
    busRd(OFS_STATUS, d);
    chk("nmiPending", 32'(d[3]), 32'h1);
    busRd(OFS_WAKE_FLAG, d);
    chk("wakeReset", d, 32'hC0);
    busRd(8'h30, d);
    chk("unmapped", d, 32'h0);
    waitAcc(VEC_NMI, 8'h30, 32'hFFFFFFFF);
    holdMask <= 1'b0;
    edg = 4'(rnd());
    ext_request_pins <= ~edg;
    busWr(OFS_EDGE_ONE, {24'h0, 4'h8, edg});
    busWr(OFS_PMODE_ONE, 32'hF);
    repeat (4) @(posedge core_clk);
    // mode change may leave stale flags
    busWr(OFS_REQ_FLAG, 32'h0);
    for (int i = 0; i < NUM_EXT; i++) begin
      ext_request_pins[i] <= edg[i];
      repeat (4) @(posedge core_clk);
      busWr(OFS_REQ_FLAG, 32'hFF);
      busRd(OFS_REQ_FLAG, d);
      chk("extFlags", d, 32'h1 << i);
      repeat (30) @(posedge core_clk);
      chk("maskedReq", 32'(reqValid), 32'h0);
      busWr(OFS_REQ_ENABLE, 32'h1 << i);
      waitAcc(VEC_EXT0 + 6'(i), OFS_REQ_FLAG, 32'h0);
      ext_request_pins[i] <= ~edg[i];
      @(posedge core_clk);
    end
    busWr(OFS_REQ_ENABLE, 32'h0);
    nonmaskPin <= 1'b1;
    waitAcc(VEC_NMI, 8'h30, 32'h0);
    nonmaskPin <= 1'b0;
    repeat (4) @(posedge core_clk);
    busRd(OFS_STATUS, d);
    chk("nmiWrongEdge", 32'(d[3]), 32'h0);
    holdMask <= 1'b1;
    wedg = 6'(rnd());
    wake_request_pins <= ~wedg;
    busWr(OFS_EDGE_TWO, {26'h0, wedg});
    busWr(OFS_PMODE_FIVE, 32'h3F);
    repeat (4) @(posedge core_clk);
    busWr(OFS_WAKE_FLAG, 32'h0);
    wake_request_pins <= wedg;
    ext_request_pins[2] <= edg[2];
    timerAReq <= 1'b1;
    directXferReq <= 1'b1;
    periphReq <= 4'hF;
    @(posedge core_clk);
    timerAReq <= 1'b0;
    directXferReq <= 1'b0;
    periphReq <= 4'h0;
    busWr(OFS_REQ_ENABLE, 32'hC4);
    busWr(OFS_PERIPH_EN, 32'hF);
    busRd(OFS_WAKE_FLAG, d);
    chk("wakeFlags", d, 32'hFF);
    chk("heldReq", 32'(reqValid), 32'h0);
    holdMask <= 1'b0;
    for (int k = 0; k < 7; k++) waitAcc(pv[k], pa[k], pd[k]);
    busWr(OFS_REQ_ENABLE, 32'h20);
    waitAcc(VEC_WAKE, OFS_WAKE_FLAG, 32'h0);
    finish_test();
  end
endmodule

// ===== verification/intc_monitor.sv
`timescale 1ns/1ps
module intc_monitor
  import intc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic instrDone,
  input wire logic globalMask,
  input wire logic [15:0] nextPc,
  input wire logic [7:0] ccrIn,
  input wire logic [15:0] stackPtr,
  input wire logic reqValid,
  input wire logic [5:0] reqVector,
  input wire logic seqBusy,
  input wire logic stackWrite,
  input wire logic [15:0] stackAddr,
  input wire logic [15:0] stackData,
  input wire logic setMask,
  input wire logic pcLoad,
  input wire logic [15:0] pcLoadValue,
  input wire logic handlerStart
);
  logic armed_ff;
  logic [15:0] spEven;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  assign spEven = {stackPtr[15:1], 1'b0};
  // Tracks the first completed instruction since reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      armed_ff <= 1'b0;
    end else if (instrDone) begin
      armed_ff <= 1'b1;
    end
  end
  a_pc_push: assert property (
    reqValid && instrDone |-> ##3 (stackWrite && stackData == $past(nextPc, 3)
      && stackAddr == $past(spEven, 3) - 16'h0002))
    else $error("counter push wrong");
  a_ccr_push: assert property (
    reqValid && instrDone |-> ##5 (stackWrite && stackData == {2{$past(ccrIn, 5)}}
      && stackAddr == $past(spEven, 5) - 16'h0004))
    else $error("flags push wrong");
  a_mask_after_stack: assert property (
    reqValid && instrDone |-> ##1 !setMask [*4] ##1 setMask)
    else $error("mask set at wrong time");
  a_vector_load: assert property (
    reqValid && instrDone |-> ##7 (pcLoad
      && pcLoadValue == {9'h000, $past(reqVector, 7), 1'b0}))
    else $error("vector load wrong");
  a_overhead_len: assert property (
    pcLoad |-> ##1 !handlerStart [*7] ##1 handlerStart)
    else $error("overhead length wrong");
  a_busy_refuse: assert property (
    seqBusy |-> !reqValid)
    else $error("request presented while busy");
  a_mask_hold: assert property (
    reqValid && globalMask |-> reqVector == VEC_NMI)
    else $error("maskable request passed mask");
  a_armed_first: assert property (
    reqValid |-> armed_ff)
    else $error("request before first instruction");
endmodule

bind external_internal_interrupt_ctrl intc_monitor u_mon (.core_clk, .reset, .instrDone,
  .globalMask, .nextPc, .ccrIn, .stackPtr, .reqValid, .reqVector, .seqBusy, .stackWrite,
  .stackAddr, .stackData, .setMask, .pcLoad, .pcLoadValue, .handlerStart);
